// File: verilog/occ_top.sv
// Behaviour
// - active source field reports current oscillator
// - requested source writable, loaded from configuration
// - lock bit plus monitor setting freezes configuration
// - pin map lock bit stored and driven
// - PLL status set when locked or timed
// - writing fail flag one acts as failure
// - oscillator writes need the unlock sequence
// - PLL input divide equals prescale plus two
// - slow ratio writes ignored while slowed
// - slow enable refused when ratio is zero
// - interrupt clears slow enable when recovering
`timescale 1ns/10ps
`default_nettype none
`include "occ_params.svh"
module occ_top
    import occ_pkg::*;
#(
    parameter int SW_CYCLES   = (`OCC_SW_TIME_NS + `OCC_CLK_NS - 1) / `OCC_CLK_NS,
    parameter int LOCK_CYCLES = (`OCC_LOCK_TIME_US * 1000 + `OCC_CLK_NS - 1) / `OCC_CLK_NS
) (
    // clock, enable, reset
    input  wire logic        clk_i,
    input  wire logic        ce_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // configuration and oscillator pins
    input  wire logic [2:0]  requested_source_cfg_i,
    input  wire logic        switch_monitor_cfg_i,
    input  wire logic        osc_fail_i,
    input  wire logic        pll_lock_i,
    input  wire logic        primary_osc_i,
    // core side
    input  wire logic        irq_event_i,
    input  wire logic        sleep_i,
    // clock control outputs
    output logic [2:0]       active_source_sel_o,
    output logic [4:0]       pll_input_prescale_o,
    output logic [5:0]       pll_input_div_o,
    output logic [8:0]       pll_feedback_mult_o,
    output logic [9:0]       pll_mult_factor_o,
    output logic             pll_locked_o,
    output logic [2:0]       cpu_slow_ratio_o,
    output logic             cpu_slow_enable_o,
    output logic             pin_map_lock_o,
    output logic             osc_fail_trap_o,
    output logic             ref_clk_o,
    output logic             irq_o
);
    localparam int SW_BND = 300;

    occ_state_t r;
    occ_state_t n;
    logic [15:0] rd16;
    logic [15:0] wd;
    logic        wr;
    logic        osc_wr;
    logic        osc_ok;
    logic        cfg_lk;
    logic        pll_on;
    logic        new_cpu_slow_enable;
    logic [3:0]  ev;
    logic [3:0]  clr;

    // ----------------------------------------------------------------
    // register read view
    // ----------------------------------------------------------------
    always_comb begin
        rd16 = 16'h0000;
        case (adr_i[5:2])
            `OCC_IDX_OSC: begin
                rd16[`OCC_OSC_ACT] = r.act;
                rd16[`OCC_OSC_REQ] = r.req;
                rd16[`OCC_OSC_CLK] = r.clock_config_lock;
                rd16[`OCC_OSC_IOL] = r.pin_map_lock;
                rd16[`OCC_OSC_LCK] = r.lock;
                rd16[`OCC_OSC_CF]  = r.cf;
                rd16[`OCC_OSC_SWE] = r.switch_enable;
            end
            `OCC_IDX_DIV: begin
                rd16[`OCC_DIV_ROI]   = r.recover_on_irq;
                rd16[`OCC_DIV_CPU_SLOW_RATIO]  = r.cpu_slow_ratio;
                rd16[`OCC_DIV_CPU_SLOW_ENABLE] = r.cpu_slow_enable;
                rd16[`OCC_DIV_PRE]   = r.pre;
            end
            `OCC_IDX_FBD: rd16[`OCC_FBD_MULT] = r.mult;
            `OCC_IDX_REF: begin
                rd16[`OCC_REF_ON]  = r.ref_out_enable;
                rd16[`OCC_REF_SLP] = r.rossl;
                rd16[`OCC_REF_SEL] = r.rosel;
                rd16[`OCC_REF_DIV] = r.ref_out_divider;
            end
            `OCC_IDX_STS: rd16[`OCC_IRQ_W-1:0] = r.sts;
            `OCC_IDX_IEN: rd16[`OCC_IRQ_W-1:0] = r.ien;
            default: rd16 = 16'h0000;
        endcase
    end

    // byte lanes 0 and 1 carry the 16-bit registers; unselected lanes keep old bits
    assign wd[7:0]  = sel_i[0] ? dat_i[7:0] : rd16[7:0];
    assign wd[15:8] = sel_i[1] ? dat_i[15:8] : rd16[15:8];
    // writes land on the edge where the master sees ack
    assign wr     = cyc_i && stb_i && we_i && r.ack;
    assign osc_wr = wr && (adr_i[5:2] == `OCC_IDX_OSC);
    assign osc_ok = osc_wr && (r.key == OCC_KEY_ARMED);
    assign cfg_lk = r.clock_config_lock && r.mon2;
    assign pll_on = (r.act == OCC_SRC_FRCP) || (r.act == OCC_SRC_PRIP);
    assign clr    = (wr && adr_i[5:2] == `OCC_IDX_CLR) ? wd[`OCC_IRQ_W-1:0] : 4'h0;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        ev = 4'h0;
        new_cpu_slow_enable = r.cpu_slow_enable;
        // two-stage synchronisers for pins from other clocks
        n.fail1 = osc_fail_i;
        n.fail2 = r.fail1;
        n.mon1  = switch_monitor_cfg_i;
        n.mon2  = r.mon1;
        n.plk1  = pll_lock_i;
        n.plk2  = r.plk1;
        n.pri1  = primary_osc_i;
        n.pri2  = r.pri1;
        n.pri3  = r.pri2;
        n.cfg1  = requested_source_cfg_i;
        n.cfg2  = r.cfg1;
        // configuration is taken once the synchroniser has filled
        if (r.init) begin
            n.init = 1'b0;
            n.req  = occ_src_t'(r.cfg2);
            n.act  = occ_src_t'(r.cfg2);
        end
        // bus slave: one wait state, ack drops after one cycle
        n.ack = cyc_i && stb_i && !r.ack;
        n.dat = rd16;
        // unlock sequence; any other write disarms it
        if (wr) begin
            n.key = OCC_KEY_NONE;
            if (adr_i[5:2] == `OCC_IDX_KEY) begin
                if (wd[7:0] == `OCC_KEY1) begin
                    n.key = OCC_KEY_HALF;
                end else if (wd[7:0] == `OCC_KEY2 && r.key == OCC_KEY_HALF) begin
                    n.key = OCC_KEY_ARMED;
                end
            end
        end
        if (osc_ok) begin
            if (!cfg_lk) begin
                n.req     = occ_src_t'(wd[`OCC_OSC_REQ]);
                n.clock_config_lock = wd[`OCC_OSC_CLK];
                if (wd[`OCC_OSC_SWE]) begin
                    n.switch_enable = 1'b1;
                end
            end
            n.pin_map_lock = wd[`OCC_OSC_IOL];
            n.cf     = wd[`OCC_OSC_CF];
        end
        if (wr && adr_i[5:2] == `OCC_IDX_DIV) begin
            n.recover_on_irq = wd[`OCC_DIV_ROI];
            if (!r.cpu_slow_enable) begin
                n.cpu_slow_ratio = wd[`OCC_DIV_CPU_SLOW_RATIO];
            end
            new_cpu_slow_enable = wd[`OCC_DIV_CPU_SLOW_ENABLE] && (n.cpu_slow_ratio != 3'h0);
            if (!cfg_lk) begin
                n.pre = wd[`OCC_DIV_PRE];
            end
        end
        if (wr && adr_i[5:2] == `OCC_IDX_FBD && !cfg_lk) begin
            n.mult = wd[`OCC_FBD_MULT];
        end
        if (wr && adr_i[5:2] == `OCC_IDX_REF) begin
            n.ref_out_enable  = wd[`OCC_REF_ON];
            n.rossl = wd[`OCC_REF_SLP];
            n.rosel = wd[`OCC_REF_SEL];
            n.ref_out_divider = wd[`OCC_REF_DIV];
        end
        if (wr && adr_i[5:2] == `OCC_IDX_IEN) begin
            n.ien = wd[`OCC_IRQ_W-1:0];
        end
        // an interrupt overrides a same-cycle write of the enable
        if (r.recover_on_irq && irq_event_i && new_cpu_slow_enable) begin
            new_cpu_slow_enable = 1'b0;
            ev[`OCC_IRQ_CPU_SLOW_RATIO] = 1'b1;
        end
        n.cpu_slow_enable = new_cpu_slow_enable;
        // hardware failure wins over a software clear
        if (r.fail2) begin
            n.cf = 1'b1;
        end
        n.trap = n.cf && !r.cf;
        ev[`OCC_IRQ_CF] = n.trap;
        // clock switch sequencer
        case (r.sw)
            OCC_SW_IDLE: begin
                n.sw_cnt = 8'h00;
                if (r.switch_enable && !r.init) begin
                    // a reserved target is dropped rather than switched to
                    if (r.req == OCC_SRC_RSV) begin
                        n.switch_enable = 1'b0;
                    end else begin
                        n.sw = OCC_SW_WAIT;
                    end
                end
            end
            OCC_SW_WAIT: begin
                if (r.sw_cnt == 8'(SW_CYCLES - 1)) begin
                    n.act   = r.req;
                    n.switch_enable = 1'b0;
                    n.sw    = OCC_SW_IDLE;
                    ev[`OCC_IRQ_SW] = 1'b1;
                end else begin
                    n.sw_cnt = r.sw_cnt + 8'h01;
                end
            end
            default: n.sw = OCC_SW_IDLE;
        endcase
        // lock timer restarts on source or divider change
        if (!pll_on || n.act != r.act || n.pre != r.pre || n.mult != r.mult) begin
            n.lk_cnt = 16'h0000;
            n.lock   = 1'b0;
        end else begin
            if (r.lk_cnt != 16'(LOCK_CYCLES)) begin
                n.lk_cnt = r.lk_cnt + 16'h0001;
            end
            n.lock = r.plk2 || (r.lk_cnt == 16'(LOCK_CYCLES));
        end
        ev[`OCC_IRQ_LCK] = n.lock && !r.lock;
        n.in_div  = {1'b0, n.pre} + `OCC_PRE_OFS;
        n.fb_mult = {1'b0, n.mult} + `OCC_PLL_OFS;
        // sticky status: an event in the clear cycle survives
        n.sts = (r.sts & ~clr) | ev;
        n.irq = |(n.sts & n.ien);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r         <= '0;
            r.init    <= 1'b1;
            r.mult    <= `OCC_RST_MULT;
            r.in_div  <= `OCC_PRE_OFS;
            r.fb_mult <= {1'b0, `OCC_RST_MULT} + `OCC_PLL_OFS;
            // config pins keep shifting through reset, so init sees the real setting
            r.cfg1    <= requested_source_cfg_i;
            r.cfg2    <= r.cfg1;
        end else if (ce_i) begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // reference output divider
    // ----------------------------------------------------------------
    occ_refdiv #(
        .DIV_W (15)
    ) u_refdiv (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .enable_i  (r.ref_out_enable && (!sleep_i || r.rossl)),
        .tick_i    (r.rosel ? (r.pri2 && !r.pri3) : 1'b1),
        .div_i     (r.ref_out_divider),
        .ref_clk_o (ref_clk_o)
    );

    assign dat_o                = {16'h0000, r.dat};
    assign ack_o                = r.ack;
    assign active_source_sel_o  = r.act;
    assign pll_input_prescale_o = r.pre;
    assign pll_input_div_o      = r.in_div;
    assign pll_feedback_mult_o  = r.mult;
    assign pll_mult_factor_o    = r.fb_mult;
    assign pll_locked_o         = r.lock;
    assign cpu_slow_ratio_o     = r.cpu_slow_ratio;
    assign cpu_slow_enable_o    = r.cpu_slow_enable;
    assign pin_map_lock_o       = r.pin_map_lock;
    assign osc_fail_trap_o      = r.trap;
    assign irq_o                = r.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    sequence s_sw_go;
        r.switch_enable && r.sw == OCC_SW_IDLE && !r.init && r.req != OCC_SRC_RSV;
    endsequence
    sequence s_sw_done;
        !r.switch_enable && r.sw == OCC_SW_IDLE;
    endsequence
    property p_switch;
        s_sw_go |-> ##[1:SW_BND] s_sw_done;
    endproperty
    a_switch: assert property (p_switch) else $error("switch never completed");
    property p_act;
        $changed(r.act) |-> $past(r.sw) == OCC_SW_WAIT || $past(r.init);
    endproperty
    a_act: assert property (p_act) else $error("active source moved without switch");
    property p_req;
        $changed(r.req) |-> $past(osc_ok) || $past(r.init);
    endproperty
    a_req: assert property (p_req) else $error("requested source changed unbidden");
    property p_cfg_lock;
        wr && adr_i[5:2] == `OCC_IDX_FBD && cfg_lk |=> $stable(r.mult);
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("locked multiplier changed");
    property p_pin_map_lock;
        osc_ok |=> pin_map_lock_o == $past(wd[`OCC_OSC_IOL]);
    endproperty
    a_pin_map_lock: assert property (p_pin_map_lock) else $error("pin map lock not stored");
    property p_pll_off;
        !pll_on |=> !pll_locked_o;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("lock shown with pll off");
    property p_cf_trap;
        osc_ok && wd[`OCC_OSC_CF] && !r.cf |=> r.cf && osc_fail_trap_o;
    endproperty
    a_cf_trap: assert property (p_cf_trap) else $error("software fail gave no trap");
    property p_unlock;
        osc_wr && r.key != OCC_KEY_ARMED |=> $stable(r.req) && $stable(r.pin_map_lock);
    endproperty
    a_unlock: assert property (p_unlock) else $error("locked oscillator write took");
    property p_prediv;
        pll_input_div_o == {1'b0, pll_input_prescale_o} + `OCC_PRE_OFS;
    endproperty
    a_prediv: assert property (p_prediv) else $error("input divide not prescale plus two");
    property p_cpu_slow_ratio_hold;
        wr && adr_i[5:2] == `OCC_IDX_DIV && r.cpu_slow_enable |=> $stable(r.cpu_slow_ratio);
    endproperty
    a_cpu_slow_ratio_hold: assert property (p_cpu_slow_ratio_hold) else $error("ratio changed while slowed");
    property p_cpu_slow_ratio_zero;
        cpu_slow_ratio_o == 3'h0 |-> !cpu_slow_enable_o;
    endproperty
    a_cpu_slow_ratio_zero: assert property (p_cpu_slow_ratio_zero) else $error("slow enabled with zero ratio");
    property p_roi;
        r.recover_on_irq && irq_event_i |=> !cpu_slow_enable_o;
    endproperty
    a_roi: assert property (p_roi) else $error("interrupt did not end slow mode");
    property p_fbmult;
        pll_mult_factor_o == {1'b0, pll_feedback_mult_o} + `OCC_PLL_OFS;
    endproperty
    a_fbmult: assert property (p_fbmult) else $error("multiplier not field plus two");
endmodule
`default_nettype wire

// File: pkg/occ_params.svh
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH
// ----------------------------------------------------------------
// register word indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define OCC_IDX_OSC     4'h0
`define OCC_IDX_DIV     4'h1
`define OCC_IDX_FBD     4'h2
`define OCC_IDX_REF     4'h3
`define OCC_IDX_STS     4'h4
`define OCC_IDX_CLR     4'h5
`define OCC_IDX_IEN     4'h6
`define OCC_IDX_KEY     4'h7
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OCC_OSC_ACT     14:12
`define OCC_OSC_REQ     10:8
`define OCC_OSC_CLK     7
`define OCC_OSC_IOL     6
`define OCC_OSC_LCK     5
`define OCC_OSC_CF      3
`define OCC_OSC_SWE     0
`define OCC_DIV_ROI     15
`define OCC_DIV_CPU_SLOW_RATIO    14:12
`define OCC_DIV_CPU_SLOW_ENABLE   11
`define OCC_DIV_PRE     4:0
`define OCC_FBD_MULT    8:0
`define OCC_REF_ON      15
`define OCC_REF_SLP     13
`define OCC_REF_SEL     12
`define OCC_REF_DIV     11:8
`define OCC_IRQ_W       4
`define OCC_IRQ_SW      0
`define OCC_IRQ_LCK     1
`define OCC_IRQ_CF      2
`define OCC_IRQ_CPU_SLOW_RATIO    3
// ----------------------------------------------------------------
// reset values, keys and timing
// ----------------------------------------------------------------
`define OCC_RST_MULT    9'h030
`define OCC_PLL_OFS     10'h002
`define OCC_PRE_OFS     6'h02
`define OCC_KEY1        8'h46
`define OCC_KEY2        8'h57
`define OCC_SW_TIME_NS  400
`define OCC_LOCK_TIME_US 200
`define OCC_CLK_NS      40
`endif

// File: pkg/occ_pkg.sv
package occ_pkg;
    typedef enum logic [2:0] {
        OCC_SRC_FRC  = 3'b000,
        OCC_SRC_FRCP = 3'b001,
        OCC_SRC_PRI  = 3'b010,
        OCC_SRC_PRIP = 3'b011,
        OCC_SRC_RSV  = 3'b100,
        OCC_SRC_LOW_POWER_RC_SOURCE = 3'b101,
        OCC_SRC_D16  = 3'b110,
        OCC_SRC_DN   = 3'b111
    } occ_src_t;
    typedef enum logic [0:0] {OCC_SW_IDLE = 1'b0, OCC_SW_WAIT = 1'b1} occ_sw_t;
    typedef enum logic [1:0] {
        OCC_KEY_NONE = 2'b00, OCC_KEY_HALF = 2'b01, OCC_KEY_ARMED = 2'b10
    } occ_key_t;
    typedef struct packed {
        logic       fail1, fail2, mon1, mon2, plk1, plk2, pri1, pri2, pri3;
        logic [2:0] cfg1, cfg2;
        logic       init;
        occ_src_t   act, req;
        logic       clock_config_lock, pin_map_lock, lock, cf, switch_enable, trap;
        occ_sw_t    sw;
        logic [7:0] sw_cnt;
        logic [15:0] lk_cnt;
        logic       recover_on_irq, cpu_slow_enable;
        logic [2:0] cpu_slow_ratio;
        logic [4:0] pre;
        logic [8:0] mult;
        logic [5:0] in_div;
        logic [9:0] fb_mult;
        logic       ref_out_enable, rossl, rosel;
        logic [3:0] ref_out_divider;
        logic [3:0] sts, ien;
        occ_key_t   key;
        logic       ack, irq;
        logic [15:0] dat;
    } occ_state_t;
endpackage

// File: verilog/occ_refdiv.sv
`timescale 1ns/10ps
`default_nettype none
`include "occ_params.svh"
module occ_refdiv #(
    parameter int DIV_W = 15
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // control
    input  wire logic       enable_i,
    input  wire logic       tick_i,
    input  wire logic [3:0] div_i,
    // output
    output logic            ref_clk_o
);
    logic [DIV_W-1:0] cnt;
    logic             next_out;

    always_comb begin
        if (!enable_i) begin
            next_out = 1'b0;
        end else if (div_i == 4'h0) begin
            next_out = tick_i;
        end else begin
            next_out = cnt[div_i - 4'h1];
        end
    end

    // counter bit k toggles every 2^k ticks, so bit code-1 divides by 2^code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt       <= '0;
            ref_clk_o <= 1'b0;
        end else if (ce_i) begin
            cnt       <= enable_i ? (tick_i ? cnt + DIV_W'(1) : cnt) : '0;
            ref_clk_o <= next_out;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);
    property p_ref_off;
        !enable_i |=> !ref_clk_o;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("ref output runs while off");
endmodule
`default_nettype wire

// File: sim/test_occ_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "occ_params.svh"
module test_occ_top;
// ----------------------------------------------------------------
// stimulus and observed signals
// ----------------------------------------------------------------
logic        clk_i = 1'b0;
logic        ce_i = 1'b1;
logic        rst_i = 1'b1;
logic        cyc_i = 1'b0;
logic        stb_i = 1'b0;
logic        we_i = 1'b0;
logic [5:0]  adr_i = 6'h00;
logic [3:0]  sel_i = 4'h0;
logic [31:0] dat_i = 32'h0;
logic [2:0]  requested_source_cfg_i = 3'h0;
logic        switch_monitor_cfg_i = 1'b0;
logic        osc_fail_i = 1'b0;
logic        pll_lock_i = 1'b0;
logic        primary_osc_i = 1'b0;
logic        irq_event_i = 1'b0;
logic        sleep_i = 1'b0;
logic [31:0] dat_o;
logic        ack_o;
logic [2:0]  active_source_sel_o;
logic [4:0]  pll_input_prescale_o;
logic [5:0]  pll_input_div_o;
logic [8:0]  pll_feedback_mult_o;
logic [9:0]  pll_mult_factor_o;
logic        pll_locked_o;
logic [2:0]  cpu_slow_ratio_o;
logic        cpu_slow_enable_o;
logic        pin_map_lock_o;
logic        osc_fail_trap_o;
logic        ref_clk_o;
logic        irq_o;
int          miscompares = 0;
int          compares = 0;
int          traps = 0;

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

// short lock time keeps the run brief
occ_top #(.SW_CYCLES(10), .LOCK_CYCLES(20)) dut (
    .clk_i, .ce_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .requested_source_cfg_i, .switch_monitor_cfg_i,
    .osc_fail_i, .pll_lock_i, .primary_osc_i, .irq_event_i, .sleep_i,
    .active_source_sel_o, .pll_input_prescale_o, .pll_input_div_o,
    .pll_feedback_mult_o, .pll_mult_factor_o, .pll_locked_o,
    .cpu_slow_ratio_o, .cpu_slow_enable_o, .pin_map_lock_o,
    .osc_fail_trap_o, .ref_clk_o, .irq_o
);

always #20 clk_i = ~clk_i;

always @(posedge clk_i) begin
    if (osc_fail_trap_o === 1'b1) begin
        traps++;
    end
end

// ----------------------------------------------------------------
// bus tasks
// ----------------------------------------------------------------
task automatic wb(input logic w, input logic [3:0] i, input logic [15:0] d,
                  output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {i, 2'b00};
    sel_i <= 4'h3;
    dat_i <= {16'h0, d};
    do begin
        @(posedge clk_i);
        n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o[15:0];
    if (n >= 50) begin
        `CHK("ack", 1'b1, ack_o)
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
endtask

task automatic wr(input logic [3:0] i, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, i, d, q);
    // registered outputs show the write only after its commit edge
    @(posedge clk_i);
endtask

task automatic rdc(input string n, input logic [3:0] i, input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, i, 16'h0, q);
    `CHK(n, e, q)
endtask

task automatic osc_wr(input logic [15:0] d);
    wr(`OCC_IDX_KEY, {8'h0, `OCC_KEY1});
    wr(`OCC_IDX_KEY, {8'h0, `OCC_KEY2});
    wr(`OCC_IDX_OSC, d);
endtask

task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
endtask

task automatic conclude;
    if (miscompares == 0 && compares > 0) begin
        $display("Run complete: PASS");
    end else begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask

// ----------------------------------------------------------------
// tests
// ----------------------------------------------------------------
initial begin
    int n;
    logic p;
    wait_clk(5);
    rst_i <= 1'b0;
    wait_clk(3);
    rdc("osc_rst", `OCC_IDX_OSC, 16'h0000);
    rdc("fbd_rst", `OCC_IDX_FBD, 16'h0030);
    `CHK("mult_rst", 10'd50, pll_mult_factor_o)
    `CHK("pre_rst", 6'd2, pll_input_div_o)
    rdc("unmapped", 4'h9, 16'h0000);
    wr(`OCC_IDX_OSC, 16'h0241);
    rdc("osc_nokey", `OCC_IDX_OSC, 16'h0000);
    osc_wr(16'h0241);
    wait_clk(14);
    rdc("osc_sw", `OCC_IDX_OSC, 16'h2240);
    `CHK("act_sw", 3'b010, active_source_sel_o)
    `CHK("pinlock", 1'b1, pin_map_lock_o)
    rdc("sts_sw", `OCC_IDX_STS, 16'h0001);
    wr(`OCC_IDX_CLR, 16'h000f);
    rdc("sts_clr", `OCC_IDX_STS, 16'h0000);
    // primary to primary-with-pll is a legal direct step
    osc_wr(16'h0341);
    wait_clk(12);
    `CHK("lock_wait", 1'b0, pll_locked_o)
    wait_clk(30);
    `CHK("lock_set", 1'b1, pll_locked_o)
    rdc("osc_pll", `OCC_IDX_OSC, 16'h3360);
    rdc("sts_pll", `OCC_IDX_STS, 16'h0003);
    wr(`OCC_IDX_CLR, 16'h000f);
    osc_wr(16'h0041);
    wait_clk(14);
    `CHK("lock_off", 1'b0, pll_locked_o)
    `CHK("act_frc", 3'b000, active_source_sel_o)
    wr(`OCC_IDX_DIV, 16'h001f);
    `CHK("pre_max", 6'd33, pll_input_div_o)
    `CHK("pre_fld", 5'h1f, pll_input_prescale_o)
    wr(`OCC_IDX_DIV, 16'h0001);
    `CHK("pre_one", 6'd3, pll_input_div_o)
    wr(`OCC_IDX_FBD, 16'h01ff);
    `CHK("mult_max", 10'd513, pll_mult_factor_o)
    `CHK("mult_fld", 9'h1ff, pll_feedback_mult_o)
    wr(`OCC_IDX_FBD, 16'h0000);
    `CHK("mult_min", 10'd2, pll_mult_factor_o)
    wr(`OCC_IDX_DIV, 16'h0800);
    `CHK("cpu_slow_ratio_zero", 1'b0, cpu_slow_enable_o)
    wr(`OCC_IDX_DIV, 16'h3800);
    `CHK("cpu_slow_ratio_on", 1'b1, cpu_slow_enable_o)
    wr(`OCC_IDX_DIV, 16'hd800);
    `CHK("cpu_slow_ratio_keep", 3'd3, cpu_slow_ratio_o)
    `CHK("irq_masked", 1'b0, irq_o)
    @(posedge clk_i);
    irq_event_i <= 1'b1;
    @(posedge clk_i);
    irq_event_i <= 1'b0;
    wait_clk(2);
    `CHK("cpu_slow_ratio_irq", 1'b0, cpu_slow_enable_o)
    // switch-done from the return to fast rc is still pending
    rdc("sts_cpu_slow_ratio", `OCC_IDX_STS, 16'h0009);
    `CHK("irq_dis", 1'b0, irq_o)
    wr(`OCC_IDX_IEN, 16'h0008);
    wait_clk(2);
    `CHK("irq_on", 1'b1, irq_o)
    wr(`OCC_IDX_CLR, 16'h0008);
    wait_clk(2);
    `CHK("irq_off", 1'b0, irq_o)
    osc_wr(16'h0048);
    wait_clk(3);
    `CHK("trap", 1, traps)
    rdc("sts_cf", `OCC_IDX_STS, 16'h0005);
    switch_monitor_cfg_i <= 1'b1;
    osc_wr(16'h00c0);
    wait_clk(4);
    wr(`OCC_IDX_FBD, 16'h0005);
    `CHK("mult_lock", 10'd2, pll_mult_factor_o)
    osc_wr(16'h02c1);
    wait_clk(14);
    rdc("osc_lock", `OCC_IDX_OSC, 16'h00c0);
    // divider only changed while the output is off
    wr(`OCC_IDX_REF, 16'h0200);
    wr(`OCC_IDX_REF, 16'h8200);
    n = 0;
    p = ref_clk_o;
    for (int k = 0; k < 64; k++) begin
        @(posedge clk_i);
        if (ref_clk_o === 1'b1 && p === 1'b0) begin
            n++;
        end
        p = ref_clk_o;
    end
    `CHK("ref_div4", 1'b1, (n >= 15 && n <= 17))
    sleep_i <= 1'b1;
    wait_clk(4);
    `CHK("ref_sleep", 1'b0, ref_clk_o)
    // a real oscillator failure traps just like the software write did
    osc_fail_i <= 1'b1;
    wait_clk(4);
    osc_fail_i <= 1'b0;
    wait_clk(3);
    `CHK("trap_pin", 2, traps)
    rdc("osc_fail", `OCC_IDX_OSC, 16'h00c8);
    // second reset: source comes from the config pins, lock from the pll pin
    requested_source_cfg_i <= 3'b011;
    pll_lock_i <= 1'b1;
    rst_i <= 1'b1;
    wait_clk(5);
    rst_i <= 1'b0;
    wait_clk(5);
    `CHK("lock_pin", 1'b1, pll_locked_o)
    rdc("osc_cfg", `OCC_IDX_OSC, 16'h3320);
    `CHK("act_cfg", 3'b011, active_source_sel_o)
    conclude();
end

initial begin
    wait_clk(5000);
    miscompares++;
    conclude();
end
endmodule
`default_nettype wire
